// >>> verilog/cpu_alu_pkg.sv
// constants and operation codes for the processor arithmetic and port datapath
// How it works
// (RULE1) a plain port input returns the synchronised pin level, not the latch
// (RULE2) read-modify-write to a port destination reads the output latch first
// (RULE3) latch readers: and, or, xor, test-clear, invert, +1, -1, loop, bit moves
// (RULE4) single-bit port ops read the full latch byte and rewrite it whole
// (RULE5) sum adds source to accumulator; sum_with_carry_in also adds carry
// (RULE6) additions: carry is carry out of bit 7, half carry out of bit 3
// (RULE7) additions: signed wrap is carry out of bit 6 xor bit 7
// (RULE8) subtract_with_borrow removes source and carry from the accumulator
// (RULE9) subtraction: carry is borrow at bit 7, half carry borrow at bit 3
// (RULE10) subtraction: signed wrap is borrow at bit 6 xor bit 7
// (RULE11) product: low byte to accumulator, high byte to second operand register
// (RULE12) product clears carry, sets signed wrap when product exceeds 255
// (RULE13) quotient: quotient to accumulator, remainder to second operand register
// (RULE14) quotient clears carry; signed wrap set only for a zero divisor
// (RULE15) bcd fix adds 0x06 when half carry set or low nibble above nine
// (RULE16) bcd fix then adds 0x60 when carry was set or first step applied
// (RULE17) bcd fix sets carry when result exceeds 0x99, clears otherwise
// (RULE18) rotate right: old bit 0 to carry, old carry to bit 7
// (RULE19) rotate left: old bit 7 to carry, old carry to bit 0
// (RULE20) compare branch jumps when values differ, falls through when equal
// (RULE21) compare branch sets carry when source greater than destination
// (RULE22) other operations leave signed wrap and half carry untouched
package cpu_alu_pkg;
   localparam int BYTE_W = 8;
   localparam int NIB_W = 4;
   localparam int SEL_W = 3;
   localparam int MSB_POS = 7;
   localparam int LSB_POS = 0;
   localparam int NIB_MSB = 3;
   localparam logic [BYTE_W-1:0] LO_ADJUST = 8'h06;
   localparam logic [BYTE_W-1:0] HI_ADJUST = 8'h60;
   localparam logic [BYTE_W:0] BCD_LIMIT = 9'h099;
   localparam logic [NIB_W-1:0] NIB_MAX = 4'h9;
   localparam logic [2*BYTE_W-1:0] BYTE_MAX = 16'h00ff;
   localparam logic [BYTE_W-1:0] ZERO_BYTE = 8'h00;
   localparam logic [BYTE_W-1:0] ONE_BYTE = 8'h01;

   typedef enum logic [4:0] {
      OP_NOP,
      OP_SUM,
      OP_SUM_CARRY,
      OP_SUB_BORROW,
      OP_PRODUCT,
      OP_QUOTIENT,
      OP_BCD_FIX,
      OP_ROT_RIGHT,
      OP_ROT_LEFT,
      OP_CMP_BRANCH,
      OP_AND,
      OP_OR,
      OP_XOR,
      OP_PLUS_ONE,
      OP_MINUS_ONE,
      OP_LOOP_JUMP,
      OP_INVERT,
      OP_INVERT_BIT,
      OP_TEST_CLEAR,
      OP_CARRY_TO_BIT,
      OP_BIT_LOW,
      OP_BIT_HIGH,
      OP_PIN_READ,
      OP_PIN_BIT_READ
   } alu_op_t;
endpackage

// >>> verilog/alu_addsub.sv
// eight-bit adder and subtractor with carry or borrow at bits 3, 6 and 7
`timescale 1ns/1ns
module alu_addsub
   import cpu_alu_pkg::*;
(
   // operands
   input wire logic [cpu_alu_pkg::BYTE_W-1:0] opA,
   input wire logic [cpu_alu_pkg::BYTE_W-1:0] opB,
   input wire logic carryIn,
   input wire logic subtract,
   // results
   output logic [cpu_alu_pkg::BYTE_W-1:0] result,
   output logic carry3,
   output logic carry6,
   output logic carry7
);
   logic [NIB_W:0] loPart;
   logic [BYTE_W-1:0] midPart;
   logic [BYTE_W:0] fullPart;

   // the top bit of each widened sum is the carry, or the borrow when subtracting
   always_comb
   begin
      if (subtract)
      begin
         loPart = {1'b0, opA[NIB_W-1:0]} - {1'b0, opB[NIB_W-1:0]} - {{NIB_W{1'b0}}, carryIn};
         midPart = {1'b0, opA[BYTE_W-2:0]} - {1'b0, opB[BYTE_W-2:0]} - {{BYTE_W-1{1'b0}}, carryIn};
         fullPart = {1'b0, opA} - {1'b0, opB} - {{BYTE_W{1'b0}}, carryIn};
      end
      else
      begin
         loPart = {1'b0, opA[NIB_W-1:0]} + {1'b0, opB[NIB_W-1:0]} + {{NIB_W{1'b0}}, carryIn};
         midPart = {1'b0, opA[BYTE_W-2:0]} + {1'b0, opB[BYTE_W-2:0]} + {{BYTE_W-1{1'b0}}, carryIn};
         fullPart = {1'b0, opA} + {1'b0, opB} + {{BYTE_W{1'b0}}, carryIn};
      end
      result = fullPart[BYTE_W-1:0];
      carry3 = loPart[NIB_W];
      carry6 = midPart[BYTE_W-1];
      carry7 = fullPart[BYTE_W];
   end
endmodule

// >>> verilog/port_bit_merge.sv
// picks one bit of a port byte and rebuilds the byte with that bit replaced
`timescale 1ns/1ns
module port_bit_merge
   import cpu_alu_pkg::*;
#(
   parameter int WIDTH = cpu_alu_pkg::BYTE_W
)
(
   // byte and bit address
   input wire logic [WIDTH-1:0] byteIn,
   input wire logic [$clog2(WIDTH)-1:0] bitSel,
   input wire logic newBit,
   // results
   output logic oldBit,
   output logic [WIDTH-1:0] byteOut
);
   localparam int SEL_BITS = $clog2(WIDTH);

   // the bit address must reach every bit of the byte and nothing beyond it
   if (WIDTH < 2 || (1 << SEL_BITS) != WIDTH)
   begin : g_width_check
      $error("port width must be a power of two and at least two");
   end

   assign oldBit = byteIn[bitSel];

   // every other bit of the byte goes back unchanged
   for (genvar i = 0; i < WIDTH; i++)
   begin : g_merge
      assign byteOut[i] = (bitSel == SEL_BITS'(i)) ? newBit : byteIn[i];
   end
endmodule

// >>> verilog/cpu_alu.sv
// processor arithmetic, flag and port read-modify-write datapath
`timescale 1ns/1ns
module cpu_alu
   import cpu_alu_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // request
   input wire logic start,
   input wire cpu_alu_pkg::alu_op_t op,
   input wire logic [cpu_alu_pkg::BYTE_W-1:0] accIn,
   input wire logic [cpu_alu_pkg::BYTE_W-1:0] bIn,
   input wire logic [cpu_alu_pkg::BYTE_W-1:0] srcIn,
   input wire logic [cpu_alu_pkg::BYTE_W-1:0] dstIn,
   input wire logic dstIsPort,
   input wire logic [cpu_alu_pkg::SEL_W-1:0] bitSel,
   // flags before the operation
   input wire logic carryIn,
   input wire logic halfIn,
   input wire logic wrapIn,
   // port
   input wire logic [cpu_alu_pkg::BYTE_W-1:0] pinLevel,
   input wire logic [cpu_alu_pkg::BYTE_W-1:0] portLatch,
   // results
   output logic done,
   output logic [cpu_alu_pkg::BYTE_W-1:0] accOut,
   output logic [cpu_alu_pkg::BYTE_W-1:0] bOut,
   output logic [cpu_alu_pkg::BYTE_W-1:0] dstOut,
   output logic dstWrite,
   output logic portWrite,
   output logic jump,
   output logic carryOut,
   output logic halfOut,
   output logic wrapOut
);
   import cpu_alu_pkg::*;

   logic [BYTE_W-1:0] pinMeta_r;
   logic [BYTE_W-1:0] pinSync_r;
   logic done_r, done_nxt;
   logic [BYTE_W-1:0] acc_r, acc_nxt;
   logic [BYTE_W-1:0] b_r, b_nxt;
   logic [BYTE_W-1:0] dst_r, dst_nxt;
   logic dstWr_r, dstWr_nxt;
   logic portWr_r, portWr_nxt;
   logic jump_r, jump_nxt;
   logic carry_r, carry_nxt;
   logic half_r, half_nxt;
   logic wrap_r, wrap_nxt;

   logic [BYTE_W-1:0] rmwByte;
   logic [BYTE_W-1:0] sumRes;
   logic sumC3, sumC6, sumC7;
   logic isSub, addCarry;
   logic newBit, oldBit;
   logic [BYTE_W-1:0] mergedByte;
   logic [2*BYTE_W-1:0] product;
   logic lowAdj, highAdj;
   logic [BYTE_W:0] bcdStep1, bcdStep2;
   logic [BYTE_W-1:0] stepByte;

   // a port destination is modified from its latch, anything else from its own value
   assign rmwByte = dstIsPort ? portLatch : dstIn; // RULE2 RULE3

   assign isSub = (op == OP_SUB_BORROW);
   assign addCarry = (op == OP_SUM) ? 1'b0 : carryIn; // RULE5 RULE8

   alu_addsub u_addsub (
      .opA(accIn),
      .opB(srcIn),
      .carryIn(addCarry),
      .subtract(isSub),
      .result(sumRes),
      .carry3(sumC3),
      .carry6(sumC6),
      .carry7(sumC7)
   );

   always_comb
   begin
      case (op)
         OP_CARRY_TO_BIT: newBit = carryIn;
         OP_BIT_HIGH: newBit = 1'b1;
         OP_INVERT_BIT: newBit = ~oldBit;
         default: newBit = 1'b0;
      endcase
   end

   port_bit_merge #(.WIDTH(BYTE_W)) u_merge (
      .byteIn(rmwByte),
      .bitSel(bitSel),
      .newBit(newBit),
      .oldBit(oldBit),
      .byteOut(mergedByte)
   );

   assign product = {{BYTE_W{1'b0}}, accIn} * {{BYTE_W{1'b0}}, bIn};
   assign lowAdj = halfIn || (accIn[NIB_W-1:0] > NIB_MAX); // RULE15
   assign highAdj = carryIn || lowAdj; // RULE16
   assign bcdStep1 = {1'b0, accIn} + {1'b0, (lowAdj ? LO_ADJUST : ZERO_BYTE)};
   assign bcdStep2 = bcdStep1 + {1'b0, (highAdj ? HI_ADJUST : ZERO_BYTE)};

   // pins come from outside the clock domain
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         pinMeta_r <= ZERO_BYTE;
         pinSync_r <= ZERO_BYTE;
      end
      else
      begin
         pinMeta_r <= pinLevel;
         pinSync_r <= pinMeta_r;
      end
   end

   always_comb
   begin
      stepByte = ZERO_BYTE;
      done_nxt = start;
      acc_nxt = acc_r;
      b_nxt = b_r;
      dst_nxt = dst_r;
      dstWr_nxt = 1'b0;
      portWr_nxt = 1'b0;
      jump_nxt = 1'b0;
      // unlisted flags pass through untouched
      carry_nxt = carryIn; // RULE22
      half_nxt = halfIn; // RULE22
      wrap_nxt = wrapIn; // RULE22
      if (start)
      begin
         acc_nxt = accIn;
         b_nxt = bIn;
         dst_nxt = rmwByte;
         case (op)
            OP_SUM, OP_SUM_CARRY, OP_SUB_BORROW:
            begin
               acc_nxt = sumRes; // RULE5 RULE8
               carry_nxt = sumC7; // RULE6 RULE9
               half_nxt = sumC3; // RULE6 RULE9
               wrap_nxt = sumC6 ^ sumC7; // RULE7 RULE10
            end
            OP_PRODUCT:
            begin
               acc_nxt = product[BYTE_W-1:0]; // RULE11
               b_nxt = product[2*BYTE_W-1:BYTE_W]; // RULE11
               carry_nxt = 1'b0; // RULE12
               wrap_nxt = (product > BYTE_MAX); // RULE12
            end
            OP_QUOTIENT:
            begin
               carry_nxt = 1'b0; // RULE14
               wrap_nxt = (bIn == ZERO_BYTE); // RULE14
               // a zero divisor leaves both registers as they were
               if (bIn != ZERO_BYTE)
               begin
                  acc_nxt = accIn / bIn; // RULE13
                  b_nxt = accIn % bIn; // RULE13
               end
            end
            OP_BCD_FIX:
            begin
               acc_nxt = bcdStep2[BYTE_W-1:0]; // RULE15 RULE16
               carry_nxt = (bcdStep2 > BCD_LIMIT); // RULE17
            end
            OP_ROT_RIGHT:
            begin
               acc_nxt = {carryIn, accIn[BYTE_W-1:1]}; // RULE18
               carry_nxt = accIn[LSB_POS]; // RULE18
            end
            OP_ROT_LEFT:
            begin
               acc_nxt = {accIn[BYTE_W-2:0], carryIn}; // RULE19
               carry_nxt = accIn[MSB_POS]; // RULE19
            end
            OP_CMP_BRANCH:
            begin
               jump_nxt = (srcIn != dstIn); // RULE20
               carry_nxt = (srcIn > dstIn); // RULE21
            end
            OP_AND, OP_OR, OP_XOR, OP_INVERT, OP_PLUS_ONE, OP_MINUS_ONE, OP_LOOP_JUMP:
            begin
               case (op)
                  OP_AND: stepByte = rmwByte & srcIn;
                  OP_OR: stepByte = rmwByte | srcIn;
                  OP_XOR: stepByte = rmwByte ^ srcIn;
                  OP_INVERT: stepByte = ~rmwByte;
                  OP_PLUS_ONE: stepByte = rmwByte + ONE_BYTE;
                  default: stepByte = rmwByte - ONE_BYTE;
               endcase
               dst_nxt = stepByte; // RULE3
               dstWr_nxt = 1'b1;
               portWr_nxt = dstIsPort; // RULE2
               jump_nxt = (op == OP_LOOP_JUMP) && (stepByte != ZERO_BYTE);
            end
            OP_INVERT_BIT, OP_CARRY_TO_BIT, OP_BIT_LOW, OP_BIT_HIGH:
            begin
               dst_nxt = mergedByte; // RULE4
               dstWr_nxt = 1'b1;
               portWr_nxt = dstIsPort; // RULE4
            end
            OP_TEST_CLEAR:
            begin
               jump_nxt = oldBit; // RULE3
               // the bit is cleared and the whole byte rewritten only when the bit was set
               dst_nxt = mergedByte; // RULE4
               dstWr_nxt = oldBit;
               portWr_nxt = dstIsPort && oldBit;
            end
            OP_PIN_READ:
               acc_nxt = pinSync_r; // RULE1
            OP_PIN_BIT_READ:
               carry_nxt = pinSync_r[bitSel]; // RULE1
            default:
               acc_nxt = accIn;
         endcase
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         done_r <= 1'b0;
         acc_r <= ZERO_BYTE;
         b_r <= ZERO_BYTE;
         dst_r <= ZERO_BYTE;
         dstWr_r <= 1'b0;
         portWr_r <= 1'b0;
         jump_r <= 1'b0;
         carry_r <= 1'b0;
         half_r <= 1'b0;
         wrap_r <= 1'b0;
      end
      else
      begin
         done_r <= done_nxt;
         acc_r <= acc_nxt;
         b_r <= b_nxt;
         dst_r <= dst_nxt;
         dstWr_r <= dstWr_nxt;
         portWr_r <= portWr_nxt;
         jump_r <= jump_nxt;
         carry_r <= carry_nxt;
         half_r <= half_nxt;
         wrap_r <= wrap_nxt;
      end
   end

   assign done = done_r;
   assign accOut = acc_r;
   assign bOut = b_r;
   assign dstOut = dst_r;
   assign dstWrite = dstWr_r;
   assign portWrite = portWr_r;
   assign jump = jump_r;
   assign carryOut = carry_r;
   assign halfOut = half_r;
   assign wrapOut = wrap_r;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   a_pin_input_read: assert property ( // RULE1
      start && op == OP_PIN_READ |=> done_r && acc_r == $past(pinSync_r))
      else $error("pin read did not return synchronised pin level");

   a_port_latch_read: assert property ( // RULE2
      start && op == OP_OR && dstIsPort |=> portWr_r && dst_r == ($past(portLatch) | $past(srcIn)))
      else $error("port update did not start from the latch");

   a_bit_merge_byte: assert property ( // RULE4
      start && op == OP_BIT_HIGH && dstIsPort
      |=> portWr_r && dst_r == ($past(portLatch) | (ONE_BYTE << $past(bitSel))))
      else $error("single bit write changed other port bits");

   a_add_flags: assert property ( // RULE6
      start && op == OP_SUM
      |=> carry_r == ((9'($past(accIn)) + 9'($past(srcIn))) > 9'h0ff)
          && acc_r == 8'($past(accIn) + $past(srcIn)))
      else $error("sum carry or result wrong");

   a_sub_borrow: assert property ( // RULE9
      start && op == OP_SUB_BORROW
      |=> carry_r == (9'($past(srcIn)) + 9'($past(carryIn)) > 9'($past(accIn))))
      else $error("borrow flag wrong after subtraction");

   a_product_flags: assert property ( // RULE12
      start && op == OP_PRODUCT |=> !carry_r && wrap_r == ({b_r, acc_r} > BYTE_MAX))
      else $error("product flags wrong");

   a_divide_zero: assert property ( // RULE14
      start && op == OP_QUOTIENT |=> !carry_r && wrap_r == ($past(bIn) == ZERO_BYTE))
      else $error("quotient flags wrong");

   a_rotate_right: assert property ( // RULE18
      start && op == OP_ROT_RIGHT
      |=> carry_r == $past(accIn[LSB_POS]) && acc_r[MSB_POS] == $past(carryIn))
      else $error("rotate right through carry wrong");

   a_rotate_left: assert property ( // RULE19
      start && op == OP_ROT_LEFT
      |=> carry_r == $past(accIn[MSB_POS]) && acc_r[LSB_POS] == $past(carryIn))
      else $error("rotate left through carry wrong");

   a_compare_jump: assert property ( // RULE20
      start && op == OP_CMP_BRANCH |=> jump_r == ($past(srcIn) != $past(dstIn)))
      else $error("compare branch decision wrong");

   a_flags_kept: assert property ( // RULE22
      start && op == OP_AND |=> half_r == $past(halfIn) && wrap_r == $past(wrapIn))
      else $error("logic op disturbed half carry or signed wrap");
endmodule

// >>> bench/tb.sv
// self-checking bench for the arithmetic, flag and port read-modify-write datapath
`timescale 1ns/1ns
`define CHK(what, expv, gotv) \
   begin \
      comparisons++; \
      if ((expv) !== (gotv)) \
      begin \
         errors++; \
         $display("Error %s expected %0h seen %0h", what, (expv), (gotv)); \
      end \
   end
module tb;
   import cpu_alu_pkg::*;
   logic mclk;
   logic rst_n;
   logic start;
   alu_op_t op;
   logic [7:0] accIn, bIn, srcIn, dstIn, pinLevel, portLatch, accOut, bOut, dstOut;
   logic dstIsPort;
   logic [2:0] bitSel;
   logic carryIn, halfIn, wrapIn;
   logic done, dstWrite, portWrite, jump, carryOut, halfOut, wrapOut;
   int errors;
   int comparisons;

   cpu_alu dut (
      .mclk, .rst_n, .start, .op, .accIn, .bIn, .srcIn, .dstIn, .dstIsPort, .bitSel,
      .carryIn, .halfIn, .wrapIn, .pinLevel, .portLatch, .done, .accOut, .bOut, .dstOut,
      .dstWrite, .portWrite, .jump, .carryOut, .halfOut, .wrapOut
   );

   initial
   begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   task automatic give_verdict();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // one operation with random operands, checked against the bench model
   task automatic run_op(input alu_op_t o, input int k);
      logic [7:0] rmw;
      logic [7:0] e;
      int a, s, c, r;
      logic lo;
      op = o;
      accIn = 8'($urandom);
      bIn = (k % 8 == 0) ? 8'h00 : 8'($urandom);
      srcIn = 8'($urandom);
      dstIn = (k % 4 == 1) ? srcIn : 8'($urandom);
      dstIsPort = (o == OP_CMP_BRANCH) ? 1'b0 : 1'($urandom);
      bitSel = 3'($urandom);
      {carryIn, halfIn, wrapIn} = 3'($urandom);
      portLatch = 8'($urandom);
      // pins always disagree with the latch so a wrong source shows
      pinLevel = ~portLatch;
      start = 1'b0;
      repeat (3) @(negedge mclk);
      start = 1'b1;
      @(negedge mclk);
      start = 1'b0;
      a = accIn;
      s = srcIn;
      c = carryIn;
      rmw = dstIsPort ? portLatch : dstIn;
      e = rmw;
      `CHK("done", 1'b1, done)
      case (o)
         OP_SUM, OP_SUM_CARRY:
         begin
            if (o == OP_SUM)
               c = 0;
            r = a + s + c;
            `CHK("sum acc", 8'(r), accOut)
            `CHK("sum carry", r > 255, carryOut)
            `CHK("sum half", (a % 16) + (s % 16) + c > 15, halfOut)
            `CHK("sum wrap", ((a % 128) + (s % 128) + c > 127) ^ (r > 255), wrapOut)
         end
         OP_SUB_BORROW:
         begin
            r = a - s - c;
            `CHK("sub acc", 8'(r), accOut)
            `CHK("sub carry", a < s + c, carryOut)
            `CHK("sub half", (a % 16) < (s % 16) + c, halfOut)
            `CHK("sub wrap", ((a % 128) < (s % 128) + c) ^ (a < s + c), wrapOut)
         end
         OP_PRODUCT:
         begin
            r = a * bIn;
            `CHK("product", 16'(r), {bOut, accOut})
            `CHK("product carry", 1'b0, carryOut)
            `CHK("product wrap", r > 255, wrapOut)
         end
         OP_QUOTIENT:
         begin
            `CHK("quotient carry", 1'b0, carryOut)
            `CHK("quotient wrap", bIn == 8'h00, wrapOut)
            if (bIn != 8'h00)
            begin
               `CHK("quotient acc", 8'(a / bIn), accOut)
               `CHK("remainder", 8'(a % bIn), bOut)
            end
         end
         OP_BCD_FIX:
         begin
            r = a;
            lo = halfIn || (a % 16 > 9);
            if (lo)
               r = r + 6;
            if (carryIn || lo)
               r = r + 96;
            `CHK("bcd acc", 8'(r), accOut)
            `CHK("bcd carry", r > 153, carryOut)
         end
         OP_ROT_RIGHT:
         begin
            `CHK("rotr acc", {carryIn, accIn[7:1]}, accOut)
            `CHK("rotr carry", accIn[0], carryOut)
         end
         OP_ROT_LEFT:
         begin
            `CHK("rotl acc", {accIn[6:0], carryIn}, accOut)
            `CHK("rotl carry", accIn[7], carryOut)
         end
         OP_CMP_BRANCH:
         begin
            `CHK("cmp jump", srcIn != dstIn, jump)
            `CHK("cmp carry", srcIn > dstIn, carryOut)
         end
         OP_AND, OP_OR, OP_XOR, OP_PLUS_ONE, OP_MINUS_ONE, OP_INVERT, OP_LOOP_JUMP:
         begin
            case (o)
               OP_AND: e = rmw & srcIn;
               OP_OR: e = rmw | srcIn;
               OP_XOR: e = rmw ^ srcIn;
               OP_PLUS_ONE: e = rmw + 8'h01;
               OP_INVERT: e = ~rmw;
               default: e = rmw - 8'h01;
            endcase
            `CHK("rmw byte", e, dstOut)
            `CHK("rmw write", 1'b1, dstWrite)
            `CHK("rmw port", dstIsPort, portWrite)
            if (o == OP_LOOP_JUMP)
               `CHK("loop jump", e != 8'h00, jump)
         end
         OP_INVERT_BIT, OP_BIT_LOW, OP_BIT_HIGH, OP_CARRY_TO_BIT, OP_TEST_CLEAR:
         begin
            case (o)
               OP_INVERT_BIT: e[bitSel] = ~rmw[bitSel];
               OP_BIT_HIGH: e[bitSel] = 1'b1;
               OP_CARRY_TO_BIT: e[bitSel] = carryIn;
               default: e[bitSel] = 1'b0;
            endcase
            lo = (o != OP_TEST_CLEAR) || rmw[bitSel];
            `CHK("bit write", lo, dstWrite)
            if (lo)
            begin
               `CHK("bit byte", e, dstOut)
               `CHK("bit port", dstIsPort, portWrite)
            end
            if (o == OP_TEST_CLEAR)
               `CHK("test jump", rmw[bitSel], jump)
         end
         OP_PIN_READ: `CHK("pin byte", pinLevel, accOut)
         OP_PIN_BIT_READ: `CHK("pin bit", pinLevel[bitSel], carryOut)
         default:
         begin
            `CHK("nop acc", accIn, accOut)
            `CHK("nop b", bIn, bOut)
         end
      endcase
      if (!(o inside {OP_SUM, OP_SUM_CARRY, OP_SUB_BORROW}))
         `CHK("half kept", halfIn, halfOut)
      if (!(o inside {OP_SUM, OP_SUM_CARRY, OP_SUB_BORROW, OP_PRODUCT, OP_QUOTIENT}))
         `CHK("wrap kept", wrapIn, wrapOut)
      if (o inside {OP_NOP, OP_AND, OP_OR, OP_XOR, OP_PLUS_ONE, OP_MINUS_ONE, OP_LOOP_JUMP, OP_INVERT,
                    OP_INVERT_BIT, OP_BIT_LOW, OP_BIT_HIGH, OP_CARRY_TO_BIT, OP_TEST_CLEAR, OP_PIN_READ})
         `CHK("carry kept", carryIn, carryOut)
      if (!(o inside {OP_CMP_BRANCH, OP_LOOP_JUMP, OP_TEST_CLEAR}))
         `CHK("no jump", 1'b0, jump)
      @(negedge mclk);
      `CHK("done pulse", 1'b0, done)
   endtask

   initial
   begin
      #(50 * 20000);
      errors++;
      give_verdict();
   end

   initial
   begin
      errors = 0;
      comparisons = 0;
      rst_n = 1'b0;
      start = 1'b0;
      op = OP_NOP;
      {accIn, bIn, srcIn, dstIn, pinLevel, portLatch} = '0;
      dstIsPort = 1'b0;
      bitSel = 3'h0;
      {carryIn, halfIn, wrapIn} = 3'h0;
      void'($urandom(32'h63e21235));
      repeat (16) @(negedge mclk);
      `CHK("reset done", 1'b0, done)
      `CHK("reset acc", 8'h00, accOut)
      rst_n = 1'b1;
      @(negedge mclk);
      // back to back: sum then subtract on consecutive edges
      op = OP_SUM;
      accIn = 8'h7f;
      srcIn = 8'h01;
      start = 1'b1;
      @(negedge mclk);
      `CHK("b2b sum acc", 8'h80, accOut)
      `CHK("b2b sum wrap", 1'b1, wrapOut)
      op = OP_SUB_BORROW;
      accIn = 8'h00;
      @(negedge mclk);
      start = 1'b0;
      `CHK("b2b sub acc", 8'hff, accOut)
      `CHK("b2b sub carry", 1'b1, carryOut)
      `CHK("b2b sub half", 1'b1, halfOut)
      `CHK("b2b sub wrap", 1'b0, wrapOut)
      $display("back to back test finished");
      for (int k = 0; k < 40; k++)
      begin
         for (int o = 0; o <= OP_PIN_BIT_READ; o++)
            run_op(alu_op_t'(o), k);
         $display("random sweep %0d finished", k);
      end
      // reset in mid-run wins over a pending request and clears every registered output
      start = 1'b1;
      op = OP_SUM;
      rst_n = 1'b0;
      repeat (2) @(negedge mclk);
      `CHK("mid reset done", 1'b0, done)
      `CHK("mid reset acc", 8'h00, accOut)
      `CHK("mid reset b", 8'h00, bOut)
      `CHK("mid reset dst", 8'h00, dstOut)
      `CHK("mid reset writes", 3'h0, {dstWrite, portWrite, jump})
      `CHK("mid reset flags", 3'h0, {carryOut, halfOut, wrapOut})
      start = 1'b0;
      rst_n = 1'b1;
      run_op(OP_SUM_CARRY, 1);
      run_op(OP_PIN_READ, 2);
      $display("mid-run reset test finished");
      give_verdict();
   end
endmodule
